/* hp_detect_consts.svh */
// Operation
// R1: right follower held off during right detection
// R2: right input clamp cleared during right detection
// R3: right output clamp inverted, set during detection
// R4: right clamp and follower bits follow output enable
// R5: pin select routes detect and feedback pins
// R6: mode field decodes five detect modes
// R7: range field selects four impedance ranges
// R8: range acts only in sense-pin modes
// R9: hold time field selects eight hold lengths
// R10: clock field sets current source tick rate
// R11: ramp bit selects normal or fast ramp
// R12: writing trigger one starts a measurement
// R13: done flag reads one when finished
// R14: level field in half-ohm steps, saturating
// R15: level meaningful only in detect modes
// R16: software re-ranges on out-of-range level
// R17: level zero below range minimum; code reports the shifted raw code with no minimum check
// R18: raw ten-bit code readable, reset zero
// R19: software sets test capacitor during detection
// R20: done stays set until next trigger
// R21: software trusts raw code 169 to 1019
// R22: completion offered as interrupt event pulse
// R23: trigger self-clears, clears done, restarts
`ifndef HP_DETECT_CONSTS_SVH
`define HP_DETECT_CONSTS_SVH

// register indices, byte address is four times the index
`define HPD_IDX_RIGHT_CTRL    14'h0226
`define HPD_IDX_ACC_MODE      14'h0293
`define HPD_IDX_CONFIG        14'h029b
`define HPD_IDX_RESULT        14'h029c
`define HPD_IDX_RAW           14'h029d
`define HPD_IDX_TEST_CAP      14'h04a4

// field positions
`define HPD_FLWR_BIT          2
`define HPD_SHRTI_BIT         1
`define HPD_SHRTO_BIT         0
`define HPD_SRC_BIT           13
`define HPD_MODE_LSB          0
`define HPD_RANGE_LSB         9
`define HPD_HOLD_LSB          5
`define HPD_DIV_LSB           3
`define HPD_RATE_BIT          1
`define HPD_TRIG_BIT          0
`define HPD_DONE_BIT          15
`define HPD_LVL_LSB           0
`define HPD_RAW_LSB           0
`define HPD_CAP_LSB           0

// reset values
`define HPD_FLWR_RST          1'h1
`define HPD_SHRTI_RST         1'h1
`define HPD_SHRTO_RST         1'h0
`define HPD_SRC_RST           1'h0
`define HPD_MODE_RST          3'h0
`define HPD_RANGE_RST         2'h0
`define HPD_HOLD_RST          3'h1
`define HPD_DIV_RST           2'h1
`define HPD_RATE_RST          1'h0
`define HPD_CAP_RST           2'h3
`define HPD_CAP_DETECT        2'h1

// timing
`define HPD_CLK_HZ            20000000
`define HPD_BASE_DET_HZ       32000
`define HPD_TICK_CYCLES       (`HPD_CLK_HZ / `HPD_BASE_DET_HZ)

// level scaling
`define HPD_LVL_MAX           15'h4e20
`define HPD_MIC_SHIFT         4

`endif

/* hp_detect_pkg.sv */
package hp_detect_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE      = 3'h0,
        ST_RAMP_UP   = 3'h1,
        ST_HOLD      = 3'h3,
        ST_RAMP_DOWN = 3'h2,
        ST_FINISH    = 3'h6
    } meas_state_e;

    typedef enum logic [2:0]
    {
        MODE_MIC_DISCRETE = 3'h0,
        MODE_HP_LEFT      = 3'h1,
        MODE_HP_RIGHT     = 3'h2,
        MODE_HP_MIC       = 3'h4,
        MODE_MIC_ADC      = 3'h7
    } detect_mode_e;

    typedef struct packed
    {
        logic [9:0] dac_code;
        logic       src_en;
        logic [1:0] impedance_range_sel;
    } current_src_s;

    typedef struct packed
    {
        logic mic_sense_pin_a;
        logic mic_sense_pin_b;
        logic ground_feedback_pin_a;
        logic ground_feedback_pin_b;
        logic left_impedance_sense_pin;
        logic right_impedance_sense_pin;
        logic mic_discrete;
        logic mic_headphone;
        logic mic_adc;
    } route_s;

    typedef struct packed
    {
        logic       right_out_follower_en;
        logic       right_out_input_clamp;
        logic       right_out_output_clamp_n;
        logic [1:0] test_cap_select;
    } right_out_s;

endpackage

/* hp_detect_measure.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hp_detect_consts.svh"

module hp_detect_measure
#(
    parameter int TICK_CYCLES = `HPD_TICK_CYCLES
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       run_en,
    input  wire logic       fast_ramp,
    input  wire logic [2:0] hold_sel,
    input  wire logic [1:0] clk_rate,
    input  wire logic       sense_trip,
    output logic      [9:0] dac_code,
    output logic            src_en,
    output logic      [9:0] raw_code,
    output logic            done_pulse
);
    import hp_detect_pkg::*;

    meas_state_e state_reg;
    meas_state_e state_next;
    logic [12:0] tick_cnt_reg;
    logic [12:0] tick_limit;
    logic        tick;
    logic [10:0] hold_cnt_reg;
    logic [10:0] hold_len;
    logic [9:0]  dac_reg;
    logic [9:0]  raw_reg;
    logic [9:0]  step;
    logic [10:0] up_sum;

    function automatic logic [10:0] hold_cycles(input logic [2:0] sel);
        case (sel)
            3'h0:    hold_cycles = 11'h001;
            3'h1:    hold_cycles = 11'h004;
            3'h2:    hold_cycles = 11'h010;
            3'h3:    hold_cycles = 11'h040;
            3'h4:    hold_cycles = 11'h100;
            3'h5:    hold_cycles = 11'h200;
            3'h6:    hold_cycles = 11'h300;
            default: hold_cycles = 11'h400;
        endcase
    endfunction

    //****************************************************************
    // detect clock tick
    //****************************************************************
    assign tick_limit = 13'(TICK_CYCLES) << clk_rate; // R10
    assign tick       = (tick_cnt_reg == tick_limit - 13'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_reg <= 13'h0;
        else if (ce)
        begin
            if (start || tick)
                tick_cnt_reg <= 13'h0;
            else
                tick_cnt_reg <= tick_cnt_reg + 13'h1;
        end
    end

    //****************************************************************
    // sequencer
    //****************************************************************
    assign step     = fast_ramp ? 10'h004 : 10'h001; // R11
    assign up_sum   = {1'b0, dac_reg} + {1'b0, step};
    assign hold_len = hold_cycles(hold_sel); // R9

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                state_next = ST_IDLE;
            ST_RAMP_UP:
                if (tick && (sense_trip || dac_reg == 10'h3ff))
                    state_next = ST_HOLD;
            ST_HOLD:
                if (tick && hold_cnt_reg == hold_len - 11'h1)
                    state_next = ST_RAMP_DOWN;
            ST_RAMP_DOWN:
                if (tick && dac_reg <= step)
                    state_next = ST_FINISH;
            ST_FINISH:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (start)
            state_next = run_en ? ST_RAMP_UP : ST_FINISH; // R12 R23
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ST_IDLE;
        else if (ce)
            state_reg <= state_next;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt_reg <= 11'h0;
        else if (ce)
        begin
            if (state_reg != ST_HOLD)
                hold_cnt_reg <= 11'h0;
            else if (tick)
                hold_cnt_reg <= hold_cnt_reg + 11'h1;
        end
    end

    // current source code ramps up to the trip, then back to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dac_reg <= 10'h0;
        else if (ce)
        begin
            if (start)
                dac_reg <= 10'h0;
            else if (tick && state_reg == ST_RAMP_UP && state_next == ST_RAMP_UP)
                dac_reg <= up_sum[10] ? 10'h3ff : up_sum[9:0];
            else if (tick && state_reg == ST_RAMP_DOWN)
                dac_reg <= (dac_reg <= step) ? 10'h0 : dac_reg - step;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_reg <= 10'h0; // R18
        else if (ce)
        begin
            if (start && !run_en)
                raw_reg <= 10'h0;
            else if (state_reg == ST_RAMP_UP && state_next == ST_HOLD)
                raw_reg <= dac_reg; // R18
        end
    end

    assign dac_code   = dac_reg;
    assign raw_code   = raw_reg;
    assign src_en     = (state_reg == ST_RAMP_UP) || (state_reg == ST_HOLD)
                        || (state_reg == ST_RAMP_DOWN);
    assign done_pulse = (state_reg == ST_FINISH) && ce;

endmodule
`default_nettype wire

/* headphone_impedance_detect_ctrl.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "hp_detect_consts.svh"

module headphone_impedance_detect_ctrl
#(
    parameter int TICK_CYCLES = `HPD_TICK_CYCLES
)
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [15:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        right_out_enable,
    input  wire logic                        sense_trip_async,
    output hp_detect_pkg::current_src_s      current_src,
    output hp_detect_pkg::route_s            route,
    output hp_detect_pkg::right_out_s        right_out,
    output logic                             measure_done_event
);
    import hp_detect_pkg::*;

    localparam int SEL_NONE  = 0;
    localparam int SEL_RIGHT = 1;
    localparam int SEL_ACC   = 2;
    localparam int SEL_CFG   = 3;
    localparam int SEL_RES   = 4;
    localparam int SEL_RAW   = 5;
    localparam int SEL_CAP   = 6;

    logic        follower_reg;
    logic        in_clamp_reg;
    logic        out_clamp_n_reg;
    logic        pin_sel_reg;
    logic [2:0]  mode_reg;
    logic [1:0]  range_reg;
    logic [2:0]  hold_reg;
    logic [1:0]  rate_reg;
    logic        ramp_fast_reg;
    logic        done_reg;
    logic [14:0] level_reg;
    logic [1:0]  cap_reg;
    logic [31:0] prdata_reg;
    logic        right_en_d_reg;
    logic        trip_meta_reg;
    logic        trip_sync_reg;

    logic [2:0]  wsel;
    logic [2:0]  rsel;
    logic        wr_en;
    logic        wr_lo;
    logic        wr_hi;
    logic        trigger;
    logic        right_rise;
    logic        right_fall;
    logic        meas_done;
    logic [9:0]  dac_code;
    logic        src_en;
    logic [9:0]  raw_code;
    logic [31:0] rd_value;

    //****************************************************************
    // decode helpers
    //****************************************************************
    function automatic logic [2:0] reg_sel(input logic [15:0] addr);
        if (addr[1:0] != 2'h0)
            reg_sel = 3'(SEL_NONE);
        else
        begin
            case (addr[15:2])
                `HPD_IDX_RIGHT_CTRL: reg_sel = 3'(SEL_RIGHT);
                `HPD_IDX_ACC_MODE:   reg_sel = 3'(SEL_ACC);
                `HPD_IDX_CONFIG:     reg_sel = 3'(SEL_CFG);
                `HPD_IDX_RESULT:     reg_sel = 3'(SEL_RES);
                `HPD_IDX_RAW:        reg_sel = 3'(SEL_RAW);
                `HPD_IDX_TEST_CAP:   reg_sel = 3'(SEL_CAP);
                default:             reg_sel = 3'(SEL_NONE);
            endcase
        end
    endfunction

    // headphone sense-pin modes
    function automatic logic is_sense_mode(input logic [2:0] mode);
        is_sense_mode = (mode == MODE_HP_LEFT) || (mode == MODE_HP_RIGHT);
    endfunction

    // any headphone impedance mode
    function automatic logic is_hp_mode(input logic [2:0] mode);
        is_hp_mode = is_sense_mode(mode) || (mode == MODE_HP_MIC);
    endfunction

    // half-ohm level from captured code, saturating at top of scale
    function automatic logic [14:0] level_of(input logic [9:0] code,
                                             input logic [2:0] mode,
                                             input logic [1:0] range);
        logic [20:0] wide;
        wide = 21'h0;
        if (mode == MODE_HP_MIC)
            wide = {11'h0, code} << `HPD_MIC_SHIFT;
        else if (is_sense_mode(mode))
            wide = {11'h0, code} << (3 * range);
        if (!is_hp_mode(mode))
            level_of = 15'h0; // R15
        else if (wide > {6'h0, `HPD_LVL_MAX})
            level_of = `HPD_LVL_MAX; // R14
        else
            level_of = wide[14:0]; // R17
    endfunction

    //****************************************************************
    // apb slave
    //****************************************************************
    assign wsel    = reg_sel(paddr);
    assign rsel    = wsel;
    assign wr_en   = psel && penable && pwrite && ce;
    assign wr_lo   = wr_en && pstrb[0];
    assign wr_hi   = wr_en && pstrb[1];
    assign trigger = wr_lo && (wsel == 3'(SEL_CFG)) && pwdata[`HPD_TRIG_BIT]; // R12 R23
    assign pready  = ce;
    assign pslverr = psel && penable && (wsel == 3'(SEL_NONE));
    assign prdata  = prdata_reg;

    always_comb
    begin
        rd_value = 32'h0;
        case (rsel)
            3'(SEL_RIGHT):
            begin
                rd_value[`HPD_FLWR_BIT]  = follower_reg;
                rd_value[`HPD_SHRTI_BIT] = in_clamp_reg;
                rd_value[`HPD_SHRTO_BIT] = out_clamp_n_reg;
            end
            3'(SEL_ACC):
            begin
                rd_value[`HPD_SRC_BIT]                   = pin_sel_reg;
                rd_value[`HPD_MODE_LSB +: 3]             = mode_reg;
            end
            3'(SEL_CFG):
            begin
                rd_value[`HPD_RANGE_LSB +: 2] = range_reg;
                rd_value[`HPD_HOLD_LSB +: 3]  = hold_reg;
                rd_value[`HPD_DIV_LSB +: 2]   = rate_reg;
                rd_value[`HPD_RATE_BIT]       = ramp_fast_reg;
            end
            3'(SEL_RES):
            begin
                rd_value[`HPD_DONE_BIT]       = done_reg; // R13
                rd_value[`HPD_LVL_LSB +: 15]  = level_reg;
            end
            3'(SEL_RAW):
                rd_value[`HPD_RAW_LSB +: 10] = raw_code; // R18
            3'(SEL_CAP):
                rd_value[`HPD_CAP_LSB +: 2] = cap_reg;
            default:
                rd_value = 32'h0;
        endcase
    end

    // read data caught in the setup cycle, held through the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0;
        else if (ce && psel && !penable)
            prdata_reg <= pwrite ? 32'h0 : rd_value;
    end

    //****************************************************************
    // right output control
    //****************************************************************
    assign right_rise = right_out_enable && !right_en_d_reg;
    assign right_fall = !right_out_enable && right_en_d_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            right_en_d_reg <= 1'b0;
        else if (ce)
            right_en_d_reg <= right_out_enable;
    end

    // output enable edge overrides a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            follower_reg    <= `HPD_FLWR_RST;
            in_clamp_reg    <= `HPD_SHRTI_RST;
            out_clamp_n_reg <= `HPD_SHRTO_RST;
        end
        else if (ce)
        begin
            if (right_rise)
            begin
                follower_reg    <= 1'b1; // R4
                in_clamp_reg    <= 1'b0; // R4
                out_clamp_n_reg <= 1'b1; // R4
            end
            else if (right_fall)
            begin
                follower_reg    <= `HPD_FLWR_RST; // R4
                in_clamp_reg    <= `HPD_SHRTI_RST; // R4
                out_clamp_n_reg <= `HPD_SHRTO_RST; // R4
            end
            else if (wr_lo && wsel == 3'(SEL_RIGHT))
            begin
                follower_reg    <= pwdata[`HPD_FLWR_BIT]; // R1
                in_clamp_reg    <= pwdata[`HPD_SHRTI_BIT]; // R2
                out_clamp_n_reg <= pwdata[`HPD_SHRTO_BIT]; // R3
            end
        end
    end

    //****************************************************************
    // mode, configuration and test capacitor registers
    //****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sel_reg <= `HPD_SRC_RST;
            mode_reg    <= `HPD_MODE_RST;
        end
        else if (ce && wsel == 3'(SEL_ACC))
        begin
            if (wr_hi)
                pin_sel_reg <= pwdata[`HPD_SRC_BIT]; // R5
            if (wr_lo)
                mode_reg <= pwdata[`HPD_MODE_LSB +: 3]; // R6
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            range_reg     <= `HPD_RANGE_RST;
            hold_reg      <= `HPD_HOLD_RST;
            rate_reg      <= `HPD_DIV_RST;
            ramp_fast_reg <= `HPD_RATE_RST;
        end
        else if (ce && wsel == 3'(SEL_CFG))
        begin
            if (wr_hi)
                range_reg[1] <= pwdata[`HPD_RANGE_LSB + 1]; // R7
            if (wr_lo)
            begin
                range_reg[0]  <= pwdata[`HPD_RANGE_LSB]; // R7
                hold_reg      <= pwdata[`HPD_HOLD_LSB +: 3]; // R9
                rate_reg      <= pwdata[`HPD_DIV_LSB +: 2]; // R10
                ramp_fast_reg <= pwdata[`HPD_RATE_BIT]; // R11
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_reg <= `HPD_CAP_RST;
        else if (ce && wr_lo && wsel == 3'(SEL_CAP))
            cap_reg <= pwdata[`HPD_CAP_LSB +: 2]; // R19
    end

    //****************************************************************
    // comparator synchroniser
    //****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_meta_reg <= 1'b0;
            trip_sync_reg <= 1'b0;
        end
        else if (ce)
        begin
            trip_meta_reg <= sense_trip_async;
            trip_sync_reg <= trip_meta_reg;
        end
    end

    //****************************************************************
    // measurement sequencer
    //****************************************************************
    hp_detect_measure
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_measure
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .start      (trigger),
        .run_en     (is_hp_mode(mode_reg)),
        .fast_ramp  (ramp_fast_reg),
        .hold_sel   (hold_reg),
        .clk_rate   (rate_reg),
        .sense_trip (trip_sync_reg),
        .dac_code   (dac_code),
        .src_en     (src_en),
        .raw_code   (raw_code),
        .done_pulse (meas_done)
    );

    //****************************************************************
    // result
    //****************************************************************
    // completion wins over a trigger in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_reg <= 1'b0;
        else if (ce)
        begin
            if (meas_done)
                done_reg <= 1'b1; // R13 R20
            else if (trigger)
                done_reg <= 1'b0; // R23
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level_reg <= 15'h0;
        else if (ce && meas_done)
            level_reg <= level_of(raw_code, mode_reg, range_reg); // R14 R15 R17
    end

    assign measure_done_event = meas_done; // R22

    //****************************************************************
    // analogue side
    //****************************************************************
    always_comb
    begin
        current_src.dac_code            = dac_code;
        current_src.src_en              = src_en;
        current_src.impedance_range_sel = is_sense_mode(mode_reg) ? range_reg : 2'h0; // R8

        route.mic_sense_pin_a           = !pin_sel_reg; // R5
        route.mic_sense_pin_b           = pin_sel_reg; // R5
        route.ground_feedback_pin_a     = !pin_sel_reg; // R5
        route.ground_feedback_pin_b     = pin_sel_reg; // R5
        route.left_impedance_sense_pin  = (mode_reg == MODE_HP_LEFT); // R6
        route.right_impedance_sense_pin = (mode_reg == MODE_HP_RIGHT); // R6
        route.mic_discrete              = (mode_reg == MODE_MIC_DISCRETE); // R6
        route.mic_headphone             = (mode_reg == MODE_HP_MIC); // R6
        route.mic_adc                   = (mode_reg == MODE_MIC_ADC); // R6

        right_out.right_out_follower_en    = follower_reg;
        right_out.right_out_input_clamp    = in_clamp_reg;
        right_out.right_out_output_clamp_n = out_clamp_n_reg;
        right_out.test_cap_select          = cap_reg;
    end

endmodule
`default_nettype wire

/* dummy_end_marker_not_used.sv */
`default_nettype none
`default_nettype wire

/* hpd_load_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// headphone load comparator
// ****
module hpd_load_model
#(
    parameter int THRESH = 40
)
(
    input  wire hp_detect_pkg::current_src_s current_src,
    output logic                             trip
);
    import hp_detect_pkg::*;
    // trips once the source current reaches the load threshold
    always_comb trip = current_src.src_en && (current_src.dac_code >= 10'(THRESH));
endmodule
`default_nettype wire

/* hpd_checker_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// port checker
// ****
module hpd_checker
#(
    parameter int TICK_CYCLES = 2
)
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         ce,
    input wire logic                         right_out_enable,
    input wire hp_detect_pkg::current_src_s  current_src,
    input wire hp_detect_pkg::route_s        route,
    input wire hp_detect_pkg::right_out_s    right_out,
    input wire logic                         measure_done_event
);
    import hp_detect_pkg::*;
    wire logic [2:0] rcfg = {right_out.right_out_follower_en,
        right_out.right_out_input_clamp, right_out.right_out_output_clamp_n};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence en_rise; ce && $rose(right_out_enable); endsequence
    sequence en_fall; ce && $fell(right_out_enable); endsequence
    chk_pin_pair: assert property (route.mic_sense_pin_a != route.mic_sense_pin_b)
        else $error("pin pair wrong");
    chk_feedback_pair: assert property (route.ground_feedback_pin_a == route.mic_sense_pin_a)
        else $error("feedback pin wrong");
    chk_mode_onehot: assert property ($onehot0({route.mic_discrete, route.mic_headphone,
        route.mic_adc, route.left_impedance_sense_pin, route.right_impedance_sense_pin}))
        else $error("mode not one hot");
    chk_range_gate: assert property (current_src.impedance_range_sel != 2'h0 |->
        route.left_impedance_sense_pin || route.right_impedance_sense_pin)
        else $error("range outside sense modes");
    chk_enable_rise: assert property (en_rise |-> ##[1:2] rcfg == 3'h5)
        else $error("enable config wrong");
    chk_enable_fall: assert property (en_fall |-> ##[1:2] rcfg == 3'h6)
        else $error("disable config wrong");
    chk_event_pulse: assert property (measure_done_event |=> !measure_done_event)
        else $error("done event too long");
    chk_src_off_done: assert property (measure_done_event |-> !current_src.src_en &&
        !current_src.dac_code)
        else $error("source on at finish");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hp_detect_consts.svh"
module tb_top;
    import hp_detect_pkg::*;
    logic               pclk, presetn, psel, penable, pwrite, ron, trip, pready, pslverr, ev, er;
    logic        [15:0] paddr;
    logic        [31:0] pwdata, prdata, rd, raw;
    current_src_s       cs;
    route_s             rt;
    right_out_s         ro;
    int                 fail_count = 0;
    int                 total_checks = 0;
    logic        [13:0] ra [6] = '{`HPD_IDX_RIGHT_CTRL, `HPD_IDX_ACC_MODE, `HPD_IDX_CONFIG,
                                   `HPD_IDX_RESULT, `HPD_IDX_RAW, `HPD_IDX_TEST_CAP};
    logic        [31:0] rv [6] = '{32'h6, 32'h0, 32'h28, 32'h0, 32'h0, 32'h3};
    headphone_impedance_detect_ctrl #(.TICK_CYCLES(2)) u_dut (.pclk, .presetn, .ce(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
        .right_out_enable(ron), .sense_trip_async(trip), .current_src(cs), .route(rt),
        .right_out(ro), .measure_done_event(ev));
    hpd_load_model u_load (.current_src(cs), .trip(trip));
    // ****
    // bus and compare tasks
    // ****
    task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_done;
        repeat (400)
        begin
            apb(1'b0, `HPD_IDX_RESULT, 32'h0);
            if (rd[15] === 1'b1) break;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end
    // ****
    // tests
    // ****
    initial
    begin
        {presetn, psel, penable, pwrite, ron, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 14'h0001, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("end reset test");
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, `HPD_IDX_ACC_MODE, {18'h0, m[0], 10'h0, m[2:0]});
            @(posedge pclk);
            chk({23'h0, rt}, {23'h0, ~m[0], m[0], ~m[0], m[0], m == 1, m == 2, m == 0, m == 4, m == 7});
        end
        $display("end route test");
        ron <= 1'b1;
        apb(1'b0, `HPD_IDX_RIGHT_CTRL, 32'h0);
        chk(rd, 32'h5);
        ron <= 1'b0;
        apb(1'b0, `HPD_IDX_RIGHT_CTRL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, `HPD_IDX_TEST_CAP, 32'h1);
        apb(1'b0, `HPD_IDX_TEST_CAP, 32'h0);
        chk({rd[29:0], ro.test_cap_select}, 32'h5);
        $display("end right test");
        apb(1'b1, `HPD_IDX_CONFIG, 32'h1);
        wait_done();
        chk(rd, 32'h8000);
        apb(1'b1, `HPD_IDX_ACC_MODE, 32'h2);
        apb(1'b1, `HPD_IDX_RIGHT_CTRL, 32'h1);
        apb(1'b1, `HPD_IDX_CONFIG, 32'h203);
        apb(1'b0, `HPD_IDX_RESULT, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, cs.impedance_range_sel}, 32'h1);
        wait_done();
        chk({31'h0, rd[15]}, 32'h1);
        apb(1'b0, `HPD_IDX_RAW, 32'h0);
        raw = rd;
        chk({31'h0, raw >= 32'd40 && raw <= 32'd52}, 32'h1);
        apb(1'b0, `HPD_IDX_RESULT, 32'h0);
        chk(rd, 32'h8000 | (raw << 3));
        apb(1'b0, `HPD_IDX_CONFIG, 32'h0);
        chk(rd, 32'h202);
        $display("end measure test");
        tally_and_finish();
    end
endmodule
bind headphone_impedance_detect_ctrl hpd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk,
    .presetn, .ce, .right_out_enable, .current_src, .route, .right_out, .measure_done_event);
`default_nettype wire
